//--- design/ovf_pkg.sv
package ovf_pkg;
  // voltages in millivolts, 16 bit codes
  localparam int VW = 16;
  localparam logic [VW-1:0] TRACK_OFFSET_MV = 16'h028F; // 655 mV
  localparam logic [VW-1:0] NODIV_MAX_MV = 16'h09FB; // 2555 mV
  // trip delay
  localparam int TRIP_DELAY_NS = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRIP_CYCLES = (TRIP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DW = 5;
  // response codes
  localparam logic [1:0] RESP_LATCH = 2'h0;
  localparam logic [1:0] RESP_IGNORE = 2'h1;
  // analog side bundle
  typedef struct packed {
    logic [VW-1:0] sense_mv;
    logic [VW-1:0] target_mv;
    logic [VW-1:0] limit_mv;
    logic no_divider;
  } ovf_volt_t;
  // control bundle
  typedef struct packed {
    logic supply_ok;
    logic enable;
    logic operation_on;
    logic clear_faults;
    logic [1:0] response;
    logic pin_selected_voltage_mode;
    logic in_regulation;
  } ovf_ctrl_t;
endpackage

//--- design/ovf_trip_delay.sv
`timescale 1ns/10ps
// qualifies the raw compare for a fixed number of cycles
module ovf_trip_delay
  import ovf_pkg::*;
#(
  parameter int CYCLES = TRIP_CYCLES
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // raw compare and delayed trip
  input wire logic raw_in,
  output logic trip_out
);
  logic [DW-1:0] cnt_r; // consecutive cycles above limit
  logic [DW-1:0] cnt_nxt;
  logic trip_r;
  logic trip_nxt;
  // count up while over, restart on any dip
  always_comb
  begin
    cnt_nxt = '0;
    trip_nxt = 1'b0;
    if (raw_in)
    begin
      cnt_nxt = (cnt_r == DW'(CYCLES)) ? cnt_r : cnt_r + 1'b1;
      trip_nxt = (cnt_r >= DW'(CYCLES - 1));
    end
  end
  // register stage
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt_r <= '0;
      trip_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      trip_r <= trip_nxt;
    end
  end
  assign trip_out = trip_r;
  chk_trip_after_delay: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(trip_r) |-> $past(raw_in, 1) && $past(cnt_r, 1) == DW'(CYCLES - 1))
    else $error("trip rose without full delay");
endmodule // ovf_trip_delay

//--- design/ovf_fault_ctrl.sv
`timescale 1ns/10ps
// overvoltage fault response: compare, delayed trip, drive latch and flags
// the compare is combinational on sense, so noise is filtered only by the
// trip delay; any dip of the compare restarts that count
// the latch keeps the high side off until supply, enable or operation drop
// status is a separate sticky flag, so a restart does not hide the event
// the ignore response still reports, it only skips the latch
// power good has two behaviours: follow regulation, or hold in pin mode
// limitation: stop sources are levels, a one-cycle drop clears the latch
module ovf_fault_ctrl
  import ovf_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // voltages and control
  input wire ovf_volt_t volt_in,
  input wire ovf_ctrl_t ctrl_in,
  // modulator requests
  input wire logic pwm_high_in,
  input wire logic pwm_low_in,
  // drives and flags
  output logic high_side_drive_out,
  output logic low_side_drive_out,
  output logic power_good_output_out,
  output logic ov_status_out,
  output logic alert_out,
  output logic trip_out
);
  // one bit of state, so no code is left unused
  typedef enum logic {OVF_RUN, OVF_LATCHED} ovf_state_t;
  ovf_state_t state_r; // drive latch
  ovf_state_t state_nxt;
  logic [VW-1:0] eff_limit; // active threshold
  logic raw_ov; // undelayed compare
  logic trip; // delayed trip
  logic status_r; // sticky fault flag
  logic status_nxt;
  logic pg_r; // power good latch
  logic pg_nxt;
  logic hs_r; // registered high side drive
  logic hs_nxt;
  logic ls_r; // registered low side drive
  logic ls_nxt;
  logic restart; // supply, enable or operation off
  // limit helper used by the compare; the check recomputes the limit inline
  function automatic logic [VW-1:0] active_limit(input ovf_volt_t v);
    // one spare bit so the sum cannot wrap
    logic [VW:0] trk;
    trk = {1'b0, v.target_mv} + {1'b0, TRACK_OFFSET_MV};
    if (v.no_divider && v.target_mv < NODIV_MAX_MV && {1'b0, v.limit_mv} > trk)
      return trk[VW-1:0];
    return v.limit_mv;
  endfunction
  // compare against limit in both voltage modes
  always_comb
  begin
    eff_limit = active_limit(volt_in);
    raw_ov = volt_in.sense_mv > eff_limit;
  end
  ovf_trip_delay #(.CYCLES(TRIP_CYCLES)) u_delay (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .raw_in(raw_ov),
    .trip_out(trip)
  );

  // any stop source clears the latch, even for one cycle
  assign restart = !ctrl_in.supply_ok || !ctrl_in.enable || !ctrl_in.operation_on;

  // latch state, status and drive next values
  always_comb
  begin
    // a stop source outranks a trip in the same cycle
    state_nxt = state_r;
    if (restart)
      state_nxt = OVF_RUN;
    else if (trip && ctrl_in.response != RESP_IGNORE)
      state_nxt = OVF_LATCHED;
    // set wins over clear
    status_nxt = trip || (status_r && !ctrl_in.clear_faults);
    // drives: modulator straight through, or the latched pattern
    hs_nxt = 1'b0;
    ls_nxt = 1'b0;
    unique case (state_nxt)
      OVF_RUN:
      begin
        hs_nxt = pwm_high_in;
        ls_nxt = pwm_low_in;
      end
      OVF_LATCHED:
      begin
        hs_nxt = 1'b0;
        ls_nxt = trip;
      end
    endcase
    // pin mode keeps good once set, only a stop or the latch clears it
    if (state_nxt == OVF_LATCHED || restart)
      pg_nxt = 1'b0;
    else if (ctrl_in.pin_selected_voltage_mode)
      pg_nxt = pg_r || ctrl_in.in_regulation;
    else
      pg_nxt = ctrl_in.in_regulation; // follows regulation every cycle
  end

  // register stage
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      // everything low and unlatched while held
      state_r <= OVF_RUN;
      status_r <= 1'b0;
      pg_r <= 1'b0;
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      status_r <= status_nxt;
      pg_r <= pg_nxt;
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
    end
  end

  // outputs straight from the registers
  assign high_side_drive_out = hs_r;
  assign low_side_drive_out = ls_r;
  assign power_good_output_out = pg_r;
  assign ov_status_out = status_r;
  assign alert_out = status_r;
  assign trip_out = trip;

  // checks on the drives and flags
  chk_latch_hs_off: assert property (@(posedge clk_in) disable iff (reset_in)
    trip && !restart && ctrl_in.response != RESP_IGNORE |=> !high_side_drive_out && !power_good_output_out)
    else $error("high side not latched off");
  chk_latch_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    state_r == OVF_LATCHED && !restart |=> state_r == OVF_LATCHED)
    else $error("latch cleared without restart");
  chk_restart_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    restart |=> state_r == OVF_RUN)
    else $error("restart did not clear latch");
  chk_low_side_on: assert property (@(posedge clk_in) disable iff (reset_in)
    state_r == OVF_LATCHED && trip && !restart |=> low_side_drive_out)
    else $error("low side dropped during overvoltage");
  chk_ignore_runs: assert property (@(posedge clk_in) disable iff (reset_in)
    ctrl_in.response == RESP_IGNORE && state_r == OVF_RUN && !restart |=> state_r == OVF_RUN)
    else $error("ignore setting latched");
  chk_status_alert: assert property (@(posedge clk_in) disable iff (reset_in)
    trip |=> ov_status_out && alert_out)
    else $error("trip not flagged");
  chk_status_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
    status_r && !ctrl_in.clear_faults |=> status_r)
    else $error("status dropped without clear");
  chk_track_limit: assert property (@(posedge clk_in) disable iff (reset_in)
    volt_in.no_divider && volt_in.target_mv < NODIV_MAX_MV && {1'b0, volt_in.limit_mv} >
    {1'b0, volt_in.target_mv} + {1'b0, TRACK_OFFSET_MV} |-> eff_limit == volt_in.target_mv + TRACK_OFFSET_MV)
    else $error("tracking limit wrong");
  chk_pin_pg_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    ctrl_in.pin_selected_voltage_mode && pg_r && state_nxt == OVF_RUN && !restart |=> pg_r)
    else $error("pin mode power good dropped");

  // the latched state never lets the high side through
  chk_latched_hs_low: assert property (@(posedge clk_in) disable iff (reset_in)
    state_r == OVF_LATCHED |-> !high_side_drive_out)
    else $error("high side on while latched");

  // power good is low for as long as the latch holds
  chk_latched_pg_low: assert property (@(posedge clk_in) disable iff (reset_in)
    state_r == OVF_LATCHED |-> !power_good_output_out)
    else $error("power good high while latched");

  // low side lets go one edge after the trip ends
  chk_ls_release: assert property (@(posedge clk_in) disable iff (reset_in)
    state_r == OVF_LATCHED && !trip && !restart |=> !low_side_drive_out)
    else $error("low side held after overvoltage");

  // outside the latch both drives follow the modulator
  chk_run_pass: assert property (@(posedge clk_in) disable iff (reset_in)
    state_nxt == OVF_RUN |=> high_side_drive_out == $past(pwm_high_in) && low_side_drive_out == $past(pwm_low_in))
    else $error("drives not following modulator");

  // a trip is only ever launched by a raw overvoltage
  chk_trip_needs_raw: assert property (@(posedge clk_in) disable iff (reset_in)
    trip |-> $past(raw_ov, 1))
    else $error("trip without raw overvoltage");

  // tracking can only lower the threshold, never raise it
  chk_limit_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    eff_limit <= volt_in.limit_mv)
    else $error("threshold above programmed limit");

  // a stop source always drops power good
  chk_restart_pg_low: assert property (@(posedge clk_in) disable iff (reset_in)
    restart |=> !power_good_output_out)
    else $error("power good survived a stop");

  // register mode power good follows regulation
  chk_digital_pg: assert property (@(posedge clk_in) disable iff (reset_in)
    !ctrl_in.pin_selected_voltage_mode && state_nxt == OVF_RUN && !restart |=>
    power_good_output_out == $past(ctrl_in.in_regulation))
    else $error("power good not following regulation");

  // pin mode raises power good on regulation
  chk_pin_pg_set: assert property (@(posedge clk_in) disable iff (reset_in)
    ctrl_in.pin_selected_voltage_mode && ctrl_in.in_regulation && state_nxt == OVF_RUN && !restart |=>
    power_good_output_out)
    else $error("pin mode power good not set");

  // clear faults drops the flag when no trip is present
  chk_status_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    status_r && ctrl_in.clear_faults && !trip |=> !status_r)
    else $error("clear faults ignored");

  // the flag only rises on a trip
  chk_status_source: assert property (@(posedge clk_in) disable iff (reset_in)
    !status_r && !trip |=> !status_r)
    else $error("status set without trip");

  // alert mirrors the status flag
  chk_alert_status: assert property (@(posedge clk_in) disable iff (reset_in)
    alert_out == ov_status_out)
    else $error("alert differs from status");
endmodule // ovf_fault_ctrl

//--- dv/ovf_sense_model.sv
`timescale 1ns/10ps
// far side: sensed output is target plus overshoot, with no lag of its own
module ovf_sense_model
  import ovf_pkg::*;
(
  // target and overshoot
  input wire logic [VW-1:0] target_in,
  input wire logic [VW-1:0] excess_in,
  // sensed output
  output logic [VW-1:0] sense_out
);
  assign sense_out = target_in + excess_in;
endmodule // ovf_sense_model

//--- dv/tb_overvoltage_fault_response.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb_overvoltage_fault_response;
  import ovf_pkg::*;
  // stimulus
  logic clk_in = 0, reset_in = 1, pwm_high = 0, pwm_low = 0, nodiv = 0;
  logic [VW-1:0] tgt = 16'h03E8, lim = 16'h0BB8, excess = 16'h0000, sense, ex, ov;
  ovf_ctrl_t ctrl = '0;
  ovf_volt_t volt;
  // observed outputs
  logic hs, ls, pg, st, al, tr;
  int mismatches = 0, checked = 0, cyc = 0, n;
  logic [31:0] rng = 32'h0000_AB46;
  assign volt = '{sense, tgt, lim, nodiv};
  assign ov = lim - tgt + 16'h0001;
  ovf_sense_model stage (.target_in(tgt), .excess_in(excess), .sense_out(sense));
  ovf_fault_ctrl DUT (.clk_in(clk_in), .reset_in(reset_in), .volt_in(volt), .ctrl_in(ctrl),
    .pwm_high_in(pwm_high), .pwm_low_in(pwm_low), .high_side_drive_out(hs), .low_side_drive_out(ls),
    .power_good_output_out(pg), .ov_status_out(st), .alert_out(al), .trip_out(tr));
  // limit the comparator should really use
  function automatic logic [VW-1:0] eff(input logic [VW-1:0] t, l, input logic nd);
    return (nd && t < NODIV_MAX_MV && l > t + TRACK_OFFSET_MV) ? t + TRACK_OFFSET_MV : l;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic complete_run;
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // raise overshoot, count edges to the delayed trip
  task automatic run_ov(input logic [VW-1:0] e, input logic exp_trip);
    @(posedge clk_in) excess <= e;
    n = 0;
    while (tr !== 1'b1 && n < TRIP_CYCLES + 1)
    begin
      @(negedge clk_in);
      n++;
    end
    `CHK(tr, exp_trip)
    if (exp_trip) `CHK(n, TRIP_CYCLES + 1)
    @(negedge clk_in);
  endtask
  // clear faults only once trip is gone, else trip wins
  task automatic restart(input int i);
    @(posedge clk_in) excess <= 16'h0000;
    repeat (3) @(posedge clk_in);
    ctrl[7-i] <= 1'b0;
    ctrl.clear_faults <= 1'b1;
    @(posedge clk_in) ctrl[7-i] <= 1'b1;
    ctrl.clear_faults <= 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  initial forever #5 clk_in = ~clk_in;
  // hang guard
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      complete_run();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    ctrl <= '{1'b1, 1'b1, 1'b1, 1'b0, RESP_LATCH, 1'b0, 1'b1};
    pwm_high <= 1'b1;
    repeat (3) @(negedge clk_in);
    `CHK(hs, 1'b1)
    // every restart source, each after a dip that must restart the count
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_in) excess <= ov;
      repeat (15) @(posedge clk_in);
      excess <= 16'h0000;
      run_ov(ov, 1'b1);
      `CHK({hs, ls, pg, st, al}, 5'b01011)
      @(posedge clk_in) excess <= 16'h0000;
      repeat (3) @(negedge clk_in);
      `CHK({tr, hs, ls, st}, 4'b0001)
      restart(i);
      `CHK({hs, st}, 2'b10)
    end
    @(posedge clk_in) ctrl.response <= RESP_IGNORE;
    pwm_high <= 1'b0;
    pwm_low <= 1'b1;
    run_ov(ov, 1'b1);
    `CHK({hs, ls, st, al}, 4'b0111)
    restart(1);
    @(posedge clk_in) ctrl.response <= RESP_LATCH;
    pwm_high <= 1'b1;
    pwm_low <= 1'b0;
    ctrl.pin_selected_voltage_mode <= 1'b1;
    repeat (3) @(posedge clk_in);
    ctrl.in_regulation <= 1'b0;
    repeat (3) @(negedge clk_in);
    `CHK(pg, 1'b1)
    run_ov(ov, 1'b1);
    `CHK({hs, pg}, 2'b00)
    restart(2);
    // random limits, tracking on and off, sense just around the limit
    for (int k = 0; k < 8; k++)
    begin
      rng = xs(rng);
      @(posedge clk_in) tgt <= {4'h0, rng[11:0]};
      lim <= {4'h0, rng[11:0]} + {4'h0, rng[27:16]} + 16'h0001;
      nodiv <= rng[31];
      ctrl.response <= rng[13:12];
      @(negedge clk_in);
      ex = eff(tgt, lim, nodiv) - tgt + {14'h0, rng[30:29]} - 16'h0001;
      run_ov(ex, rng[30]);
      `CHK(hs, !rng[30] || rng[13:12] == RESP_IGNORE)
      restart(0);
    end
    complete_run();
  end
endmodule // tb_overvoltage_fault_response
